// ---- shared/crrs_pkg.sv ----
/*
  Constants and types for the return, rotate, halt and literal-subtract
  execution block. Assumes a 14-bit instruction word of the 8-bit core.
*/
package crrs_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned PC_W         = 13;
  localparam int unsigned FADDR_W      = 7;
  localparam int unsigned STACK_DEPTH  = 8;
  localparam int unsigned INSN_W       = 14;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam logic [3:0] NIBBLE_MASK   = 4'hf;
  localparam int unsigned MSB          = 7;
  localparam int unsigned DEST_BIT     = 7;
  localparam int unsigned WATCHDOG_W   = 8;
  localparam logic [WATCHDOG_W-1:0] WATCHDOG_ZERO = 8'h00;
  localparam logic [13:0] RETURN_CODE  = 14'h0008;
  localparam logic [13:0] HALT_CODE    = 14'h0063;
  localparam logic [5:0]  ROTL_OPC     = 6'h0d;
  localparam logic [5:0]  ROTR_OPC     = 6'h0c;
  localparam logic [4:0]  LITSUB_OPC   = 5'h1e;
  localparam int unsigned OPC_LSB      = 8;
  localparam int unsigned LITSUB_LSB   = 9;
  localparam int unsigned LIT_W        = 8;
  localparam int unsigned NIB_W        = 4;

  typedef enum logic [1:0] {
    CRRS_RUN    = 2'b00,
    CRRS_FLUSH  = 2'b01,
    CRRS_HALTED = 2'b10
  } crrs_state_t;
endpackage

// ---- verilog/crrs_stack.sv ----
/*
  Hardware return stack: a circular array of program-counter values.
  Assumes push and pop never occur in the same cycle.
*/
`timescale 1ns/1ns
module crrs_stack #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             reset,
  // Control.
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_value,
  input  wire logic             pop,
  // Registered top of stack.
  output logic      [WIDTH-1:0] top
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("Stack depth must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] next_ptr;
  logic [WIDTH-1:0] next_top;

  // The stack wraps silently; overflow is not flagged, so a call chain deeper
  // than the stack loses its oldest return address.
  always_comb begin
    next_ptr = ptr;
    next_top = top;
    if (push) begin
      next_ptr = ptr + PTR_W'(1);
      next_top = push_value;
    end else if (pop) begin
      next_ptr = ptr - PTR_W'(1);
      next_top = mem[ptr - PTR_W'(1)];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ptr <= '0;
      top <= '0;
    end else begin
      ptr <= next_ptr;
      top <= next_top;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[ptr + PTR_W'(1)] <= push_value;
    end
  end
endmodule // crrs_stack

// ---- verilog/crrs_exec.sv ----
/*
  Execution unit for return, rotate left/right through carry, halt and
  literal subtract. Assumes the fetch stage presents one decoded word per
  cycle with insn_valid, reads file data combinationally and honours the
  flush and osc_stop outputs.
*/
// Functional notes
// - Return pops the stack into the program counter; flags untouched.
// - Return takes two cycles; the prefetched word is discarded.
// - Rotate left: carry into bit 0, old bit 7 to carry only.
// - Rotate left destination zero writes accumulator, one writes the file register.
// - Rotate right: carry into bit 7, old bit 0 to carry only.
// - Rotate right destination zero writes accumulator, one writes the file register.
// - Halt clears power-down flag, sets time-out flag, no other status flag.
// - Halt clears the watchdog count and its prescaler.
// - After halt the core sleeps, oscillator stopped, until wake-up.
// - Literal subtract: literal minus accumulator into accumulator; updates carry, nibble, zero.
`timescale 1ns/1ns
module crrs_exec
  import crrs_pkg::*;
#(
  parameter int unsigned STACK_N = crrs_pkg::STACK_DEPTH
) (
  // Clock and reset.
  input  wire logic                          clock,
  input  wire logic                          reset,
  // Instruction from fetch.
  input  wire logic                          insn_valid,
  input  wire logic [crrs_pkg::INSN_W-1:0]   insn,
  input  wire logic [crrs_pkg::PC_W-1:0]     pc_in,
  input  wire logic                          call_push,
  input  wire logic                          wake_event,
  // File register read data.
  input  wire logic [crrs_pkg::DATA_W-1:0]   file_rdata,
  // File register write port.
  output logic                               file_we,
  output logic [crrs_pkg::FADDR_W-1:0]       file_addr,
  output logic [crrs_pkg::DATA_W-1:0]        file_wdata,
  // Core state.
  output logic [crrs_pkg::DATA_W-1:0]        acc,
  output logic [crrs_pkg::PC_W-1:0]          program_counter,
  output logic                               pc_load,
  output logic                               flush,
  output logic                               carry_flag,
  output logic                               nibble_carry_flag,
  output logic                               zero_flag,
  output logic                               timeout_status_flag,
  output logic                               powerdown_status_flag,
  output logic                               watchdog_clear,
  output logic                               osc_stop
);
  import crrs_pkg::*;

  if (STACK_N < 2) begin : g_bad_stack
    $error("Return stack needs at least two entries.");
  end

  crrs_state_t state;
  crrs_state_t next_state;
  logic [PC_W-1:0] stack_top_value;
  logic            do_pop;

  logic [DATA_W-1:0] next_acc;
  logic [DATA_W-1:0] next_file_wdata;
  logic [FADDR_W-1:0] next_file_addr;
  logic next_file_we, next_c, next_nibble, next_z, next_timeout, next_powerdown;
  logic next_watchdog, next_stop, next_pc_load, next_flush;
  logic [PC_W-1:0] next_pc;
  logic [DATA_W:0] diff;
  logic [NIB_W:0]  ndiff;
  logic            dest;
  logic            rotate_left_carry_op;
  logic            rotate_right_carry_op;
  logic            literal_minus_acc_op;
  logic            is_return;
  logic            is_halt;

  crrs_stack #(
    .WIDTH (PC_W),
    .DEPTH (STACK_N)
  ) u_stack (
    .clock      (clock),
    .reset      (reset),
    .push       (call_push),
    .push_value (pc_in),
    .pop        (do_pop),
    .top        (stack_top_value)
  );

  assign dest = insn[DEST_BIT];
  assign rotate_left_carry_op  = insn[INSN_W-1:OPC_LSB] == ROTL_OPC;
  assign rotate_right_carry_op = insn[INSN_W-1:OPC_LSB] == ROTR_OPC;
  assign literal_minus_acc_op  = insn[INSN_W-1:LITSUB_LSB] == LITSUB_OPC;
  assign is_return = insn == RETURN_CODE;
  assign is_halt   = insn == HALT_CODE;
  assign do_pop = (state == CRRS_RUN) && insn_valid && is_return;

  always_comb begin
    next_state      = state;
    next_acc        = acc;
    next_file_we    = 1'b0;
    next_file_addr  = file_addr;
    next_file_wdata = file_wdata;
    next_c          = carry_flag;
    next_nibble     = nibble_carry_flag;
    next_z          = zero_flag;
    next_timeout    = timeout_status_flag;
    next_powerdown  = powerdown_status_flag;
    next_watchdog   = 1'b0;
    next_stop       = osc_stop;
    next_pc         = program_counter;
    next_pc_load    = 1'b0;
    next_flush      = 1'b0;
    diff  = {1'b0, insn[LIT_W-1:0]} - {1'b0, acc};
    ndiff = {1'b0, insn[NIB_W-1:0] & NIBBLE_MASK} - {1'b0, acc[NIB_W-1:0]};
    case (state)
      CRRS_RUN: begin
        if (insn_valid) begin
          if (is_return) begin
            next_pc      = stack_top_value;
            next_pc_load = 1'b1;
            next_flush   = 1'b1;
            next_state   = CRRS_FLUSH;
          end else if (is_halt) begin
            next_powerdown = 1'b0;
            next_timeout   = 1'b1;
            next_watchdog  = 1'b1;
            next_stop  = 1'b1;
            next_state = CRRS_HALTED;
          end else if (rotate_left_carry_op || rotate_right_carry_op) begin
            if (rotate_left_carry_op) begin
              next_file_wdata = {file_rdata[MSB-1:0], carry_flag};
              next_c          = file_rdata[MSB];
            end else begin
              next_file_wdata = {carry_flag, file_rdata[MSB:1]};
              next_c          = file_rdata[0];
            end
            next_file_addr = insn[FADDR_W-1:0];
            if (dest) begin
              next_file_we = 1'b1;
            end else begin
              next_acc = next_file_wdata;
            end
          end else if (literal_minus_acc_op) begin
            next_acc = diff[DATA_W-1:0];
            next_c   = ~diff[DATA_W];
            next_nibble = ~ndiff[NIB_W];
            next_z   = diff[DATA_W-1:0] == ZERO_BYTE;
          end
        end
      end
      CRRS_FLUSH: begin
        // The word fetched behind the return is dropped here.
        next_state = CRRS_RUN;
      end
      CRRS_HALTED: begin
        if (wake_event) begin
          next_stop  = 1'b0;
          next_state = CRRS_RUN;
        end
      end
      default: begin
        next_state = CRRS_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state                 <= CRRS_RUN;
      acc                   <= '0;
      file_we               <= 1'b0;
      file_addr             <= '0;
      file_wdata            <= '0;
      carry_flag            <= 1'b0;
      nibble_carry_flag     <= 1'b0;
      zero_flag             <= 1'b0;
      timeout_status_flag   <= 1'b1;
      powerdown_status_flag <= 1'b1;
      watchdog_clear        <= 1'b0;
      osc_stop              <= 1'b0;
      program_counter       <= '0;
      pc_load               <= 1'b0;
      flush                 <= 1'b0;
    end else begin
      state                 <= next_state;
      acc                   <= next_acc;
      file_we               <= next_file_we;
      file_addr             <= next_file_addr;
      file_wdata            <= next_file_wdata;
      carry_flag            <= next_c;
      nibble_carry_flag     <= next_nibble;
      zero_flag             <= next_z;
      timeout_status_flag   <= next_timeout;
      powerdown_status_flag <= next_powerdown;
      watchdog_clear        <= next_watchdog;
      osc_stop              <= next_stop;
      program_counter       <= next_pc;
      pc_load               <= next_pc_load;
      flush                 <= next_flush;
    end
  end

  a_return_pc: assert property (@(posedge clock) disable iff (reset)
    do_pop |=> pc_load && program_counter == $past(stack_top_value))
    else $error("Return did not load the popped stack value.");
  a_return_flags: assert property (@(posedge clock) disable iff (reset)
    do_pop |=> $stable(carry_flag) && $stable(zero_flag) && $stable(nibble_carry_flag))
    else $error("Return changed a status flag.");
  a_return_two: assert property (@(posedge clock) disable iff (reset)
    do_pop |=> state == CRRS_FLUSH ##1 state == CRRS_RUN && !file_we)
    else $error("Return did not take two cycles.");
  a_rotl_value: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && rotate_left_carry_op |=>
      file_wdata == {$past(file_rdata[MSB-1:0]), $past(carry_flag)}
      && carry_flag == $past(file_rdata[MSB])
      && $stable(zero_flag) && $stable(nibble_carry_flag))
    else $error("Rotate left result wrong.");
  a_rotl_dest: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && rotate_left_carry_op |=>
      file_we == $past(dest) && (file_we || acc == file_wdata))
    else $error("Rotate left destination wrong.");
  a_rotr_value: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && rotate_right_carry_op |=>
      file_wdata == {$past(carry_flag), $past(file_rdata[MSB:1])}
      && carry_flag == $past(file_rdata[0]) && $stable(zero_flag)
      && $stable(nibble_carry_flag))
    else $error("Rotate right result wrong.");
  a_rotr_dest: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && rotate_right_carry_op && !dest |=>
      !file_we && acc == file_wdata)
    else $error("Rotate right destination wrong.");
  a_halt_flags: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && is_halt |=>
      !powerdown_status_flag && timeout_status_flag && $stable(carry_flag)
      && $stable(zero_flag) && $stable(nibble_carry_flag))
    else $error("Halt status flags wrong.");
  a_halt_watchdog: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && is_halt |=> watchdog_clear ##1 !watchdog_clear)
    else $error("Halt did not pulse watchdog clear.");
  a_halt_sleep: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_HALTED && !wake_event |=> osc_stop && state == CRRS_HALTED)
    else $error("Core left sleep without wake-up.");
  a_sub_value: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && literal_minus_acc_op |=>
      acc == 8'($past(insn[7:0]) - $past(acc)))
    else $error("Literal subtract result wrong.");
  a_sub_flags: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && literal_minus_acc_op |=>
      carry_flag == ($past(acc) <= $past(insn[7:0]))
      && nibble_carry_flag == ($past(acc[3:0]) <= $past(insn[3:0]))
      && zero_flag == (acc == ZERO_BYTE))
    else $error("Literal subtract flags wrong.");
  a_single_cycle: assert property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid
      && (literal_minus_acc_op || rotate_left_carry_op || rotate_right_carry_op)
      |=> state == CRRS_RUN)
    else $error("Single-cycle instruction stalled.");

  c_return: cover property (@(posedge clock) disable iff (reset) do_pop);
  c_halt_wake: cover property (@(posedge clock) disable iff (reset)
    state == CRRS_HALTED ##1 state == CRRS_RUN);
  c_sub_zero: cover property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && literal_minus_acc_op ##1 zero_flag);
  c_rotr_file: cover property (@(posedge clock) disable iff (reset)
    state == CRRS_RUN && insn_valid && rotate_right_carry_op && dest);
endmodule // crrs_exec

// ---- testbench/test_crrs_exec.sv ----
/*
  Self-checking bench for the return, rotate, halt and literal-subtract unit.
  Assumes registered answers one cycle after the taking edge and the opcode
  constants of crrs_pkg; the bench plays the fetch stage and file registers.
*/
`timescale 1ns/1ns
module test_crrs_exec;
  import crrs_pkg::*;

  logic               clock;
  logic               reset;
  logic               insn_valid;
  logic [INSN_W-1:0]  insn;
  logic [PC_W-1:0]    pc_in;
  logic               call_push;
  logic               wake_event;
  logic [DATA_W-1:0]  file_rdata;
  logic               file_we;
  logic [FADDR_W-1:0] file_addr;
  logic [DATA_W-1:0]  file_wdata;
  logic [DATA_W-1:0]  acc;
  logic [PC_W-1:0]    program_counter;
  logic               pc_load;
  logic               flush;
  logic               carry_flag;
  logic               nibble_carry_flag;
  logic               zero_flag;
  logic               timeout_status_flag;
  logic               powerdown_status_flag;
  logic               watchdog_clear;
  logic               osc_stop;
  int                 num_errors = 0;
  int                 checks_done = 0;
  int                 cycles = 0;
  logic [7:0]         m_acc;
  logic               m_c, m_nibble, m_z;

  crrs_exec dut (
    .clock(clock), .reset(reset), .insn_valid(insn_valid), .insn(insn),
    .pc_in(pc_in), .call_push(call_push), .wake_event(wake_event),
    .file_rdata(file_rdata), .file_we(file_we), .file_addr(file_addr),
    .file_wdata(file_wdata), .acc(acc), .program_counter(program_counter),
    .pc_load(pc_load), .flush(flush), .carry_flag(carry_flag),
    .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
    .timeout_status_flag(timeout_status_flag),
    .powerdown_status_flag(powerdown_status_flag),
    .watchdog_clear(watchdog_clear), .osc_stop(osc_stop)
  );

  always #25 clock = ~clock;

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_flags();
    check_val(16'(carry_flag), 16'(m_c), "carry");
    check_val(16'(nibble_carry_flag), 16'(m_nibble), "nibble carry");
    check_val(16'(zero_flag), 16'(m_z), "zero");
  endtask

  task automatic send(input logic [INSN_W-1:0] w, input logic [7:0] d);
    @(posedge clock);
    insn_valid <= 1'b1;
    insn       <= w;
    file_rdata <= d;
  endtask

  task automatic idle();
    @(posedge clock);
    insn_valid <= 1'b0;
  endtask

  // Expected results come from plain arithmetic, never from the unit's outputs.
  function automatic void model_sub(input logic [7:0] k);
    logic [8:0] d;
    logic [4:0] n;
    d = {1'b0, k} - {1'b0, m_acc};
    n = {1'b0, k[3:0]} - {1'b0, m_acc[3:0]};
    m_acc = d[7:0];
    m_c = ~d[8];
    m_nibble = ~n[4];
    m_z = (d[7:0] == 8'h00);
  endfunction

  task automatic test_reset();
    @(posedge clock);
    reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    m_acc = 8'h00;
    m_c = 1'b0;
    m_nibble = 1'b0;
    m_z = 1'b0;
    check_val(16'(acc), 16'h0000, "accumulator after reset");
    check_flags();
    check_val(16'(timeout_status_flag), 16'h0001, "time-out after reset");
    check_val(16'(powerdown_status_flag), 16'h0001, "power-down after reset");
    check_val(16'(osc_stop), 16'h0000, "stopped after reset");
    $display("test reset done");
  endtask

  task automatic rot(input logic left, input logic dest, input logic [6:0] a,
                     input logic [7:0] f);
    logic [7:0] r;
    logic       nc;
    r  = left ? {f[6:0], m_c} : {m_c, f[7:1]};
    nc = left ? f[7] : f[0];
    send({left ? ROTL_OPC : ROTR_OPC, dest, a}, f);
    idle();
    @(negedge clock);
    m_c = nc;
    check_flags();
    check_val(16'(file_we), 16'(dest), "file write");
    if (dest) begin
      check_val(16'(file_addr), 16'(a), "file address");
      check_val(16'(file_wdata), 16'(r), "file data");
    end else begin
      m_acc = r;
    end
    check_val(16'(acc), 16'(m_acc), "rotated accumulator");
    @(negedge clock);
    check_val(16'(file_we), 16'h0000, "file write pulse");
    $display("test rotate done");
  endtask

  task automatic sub(input logic [7:0] k);
    // File data is junk here, so a subtract that read it would show.
    send({LITSUB_OPC, 1'b0, k}, 8'h5a);
    idle();
    @(negedge clock);
    model_sub(k);
    check_val(16'(acc), 16'(m_acc), "difference");
    check_flags();
    $display("test subtract done");
  endtask

  task automatic test_back_to_back();
    check_val(16'(file_we), 16'h0000, "idle write");
    send({ROTL_OPC, 1'b1, 7'h11}, 8'h95);
    send({LITSUB_OPC, 1'b0, 8'h10}, 8'h5a);
    @(negedge clock);
    check_val(16'(file_we), 16'h0001, "first of pair");
    check_val(16'(file_wdata), 16'({7'h15, m_c}), "first result");
    check_val(16'(carry_flag), 16'h0001, "carry from bit 7");
    idle();
    @(negedge clock);
    model_sub(8'h10);
    check_val(16'(acc), 16'(m_acc), "second of pair");
    check_flags();
    check_val(16'(file_we), 16'h0000, "no second write");
    $display("test back to back done");
  endtask

  task automatic test_return();
    logic [PC_W-1:0] pcs [2];
    pcs = '{13'h1a5c, 13'h0123};
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      call_push <= 1'b1;
      pc_in     <= pcs[i];
    end
    @(posedge clock);
    call_push <= 1'b0;
    for (int i = 1; i >= 0; i--) begin
      // The word behind the return sits in the flush cycle and must die.
      send(RETURN_CODE, 8'h00);
      send({ROTL_OPC, 1'b0, 7'h01}, 8'hff);
      @(negedge clock);
      check_val(16'(program_counter), 16'(pcs[i]), "popped value");
      check_val(16'(pc_load), 16'h0001, "load pulse");
      check_val(16'(flush), 16'h0001, "flush pulse");
      check_flags();
      idle();
      @(negedge clock);
      check_val(16'(flush), 16'h0000, "flush end");
      check_val(16'(pc_load), 16'h0000, "load end");
      check_val(16'(acc), 16'(m_acc), "flushed word");
    end
    $display("test return done");
  endtask

  task automatic test_halt();
    send(HALT_CODE, 8'h00);
    send({ROTR_OPC, 1'b0, 7'h02}, 8'hff);
    @(negedge clock);
    check_val(16'(powerdown_status_flag), 16'h0000, "power-down");
    check_val(16'(timeout_status_flag), 16'h0001, "time-out");
    check_flags();
    check_val(16'(watchdog_clear), 16'h0001, "watchdog clear");
    check_val(16'(osc_stop), 16'h0001, "stopped");
    repeat (4) @(posedge clock);
    @(negedge clock);
    check_val(16'(watchdog_clear), 16'h0000, "clear pulse");
    check_val(16'(acc), 16'(m_acc), "word while halted");
    check_val(16'(osc_stop), 16'h0001, "still stopped");
    @(posedge clock);
    insn_valid <= 1'b0;
    wake_event <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    @(negedge clock);
    check_val(16'(osc_stop), 16'h0000, "woken");
    check_val(16'(powerdown_status_flag), 16'h0000, "power-down kept");
    $display("test halt done");
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The whole run needs under a hundred cycles; the ceiling of 2000 leaves ample slack.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      $display("unexpected at %0t ns: run did not finish", $time);
      results();
    end
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    insn_valid = 1'b0;
    insn = 14'h0000;
    pc_in = 13'h0000;
    call_push = 1'b0;
    wake_event = 1'b0;
    file_rdata = 8'h00;
    test_reset();
    rot(1'b1, 1'b0, 7'h21, 8'he6);
    rot(1'b1, 1'b1, 7'h7f, 8'h01);
    rot(1'b0, 1'b0, 7'h00, 8'h81);
    rot(1'b0, 1'b1, 7'h45, 8'h02);
    sub(8'h40);
    rot(1'b1, 1'b0, 7'h12, 8'h19);
    sub(8'h20);
    sub(8'hff);
    sub(8'h13);
    sub(8'h30);
    test_back_to_back();
    test_return();
    test_halt();
    rot(1'b0, 1'b0, 7'h33, 8'h3c);
    test_reset();
    results();
  end
endmodule // test_crrs_exec
